//--- acr_bank.sv
// Purpose: Control and status register bank of a stereo amplifier, two-wire serial slave
// Assumes: scl_i and sda_i synchronous to clk and slow against it
// Notes:   Open-drain data pin; sda_oe_o high pulls the line low
//
// Overview of operation
// (R01) Registers one to seven reset to c3, 05, 0b, 00, 06, 3a, c2.
// (R02) Host never writes addresses above eight; such writes are dropped here.
// (R03) Reserved addresses read as arbitrary data; here they read zero.
// (R04) Slave answers address byte b0 for writes and b1 for reads.
// (R05) Function bit 7 enables right channel, bit 6 left, both default one.
// (R06) Channel enable acts only while die temperature stays below threshold.
// (R07) Function bit 5 set puts device in software shutdown, default clear.
// (R08) Function bit 4 sets on right channel short or over-current.
// (R09) Right fault bit stays set until host writes zero to it.
// (R10) Function bit 3 sets on left short, cleared by host writing zero.
// (R11) Function bit 2 sets on hardware thermal shutdown.
// (R12) Thermal flag is deglitched, latched, cleared by writing zero.
// (R13) Function bit 0 enables noise gate, active only with ratio not 1:1.
// (R14) Compression ratio is register seven bits 1:0.
// (R15) Write: first byte selects register, following bytes fill successive registers.
// (R16) Read: successive registers returned while master acknowledges each byte.
// (R17) Writing one to a flag leaves it; only hardware sets flags.
// (R18) Function bit 1 reads one and ignores writes.
`timescale 1ns/1ps
module acr_bank
  import acr_pkg::*;
#(
  parameter int DEGLITCH = DEGLITCH_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Protection inputs
  input wire logic fault_right_i,
  input wire logic fault_left_i,
  input wire logic over_temp_i,
  // Amplifier controls
  output acr_amp_type amp_o,
  output acr_cfg_type cfg_o
);

  acr_core_type state_r;
  acr_core_type nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic therm_hot;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;
  logic [7:0] fc;

  // ----------------------------------------------------------------
  // Register access helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_reg(input logic [7:0][7:0] regs, input logic [7:0] ptr);
    logic [7:0] v;
    v = RD_UNMAPPED;
    if (ptr >= REG_FUNC && ptr <= REG_MAXGAIN) begin
      v = regs[ptr[2:0]];
    end
    return v;
  endfunction : read_reg

  function automatic logic [7:0][7:0] write_reg(input logic [7:0][7:0] regs, input logic [7:0] ptr,
                                               input logic [7:0] d);
    logic [7:0][7:0] v;
    v = regs;
    if (ptr == REG_FUNC) begin
      v[1] = (d & FC_WMASK) | (regs[1] & d & FC_FLAGS) | FC_ONE; // R17 R18 R09
    end else if (ptr >= REG_ATTACK && ptr <= REG_MAXGAIN) begin
      v[ptr[2:0]] = d & REG_WMASK[ptr[2:0]]; // R15
    end
    return v; // R02
  endfunction : write_reg

  // ----------------------------------------------------------------
  // Thermal qualification
  // ----------------------------------------------------------------
  acr_deglitch #(
    .CYCLES(DEGLITCH)
  ) u_therm (
    .clk(clk),
    .rst(rst),
    .level_i(over_temp_i),
    .stable_o(therm_hot)
  ); // R12

  assign scl_rise = scl_i & ~state_r.scl_q;
  assign scl_fall = ~scl_i & state_r.scl_q;
  assign start_cond = scl_i & state_r.scl_q & state_r.sda_q & ~sda_i;
  assign stop_cond = scl_i & state_r.scl_q & ~state_r.sda_q & sda_i;
  assign rd_byte = read_reg(state_r.regs, state_r.ptr); // R03
  assign fc = state_r.regs[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt = state_r;
    wr_en = 1'b0;
    wr_data = state_r.shift;
    nxt.scl_q = scl_i;
    nxt.sda_q = sda_i;
    case (state_r.state)
      S_IDLE: begin
        nxt.sda_oe = 1'b0;
      end
      S_RX: begin
        if (scl_rise && state_r.cnt < 4'h8) begin
          nxt.shift = {state_r.shift[6:0], sda_i};
          nxt.cnt = state_r.cnt + 4'h1;
        end else if (scl_fall && state_r.cnt == 4'h8) begin
          nxt.cnt = 4'h0;
          case (state_r.phase)
            PH_ADDR: begin
              if (state_r.shift[7:1] == SLAVE_ADDR) begin // R04
                nxt.rw = state_r.shift[0];
                nxt.state = S_ACK;
                nxt.sda_oe = 1'b1;
                nxt.phase = PH_PTR;
              end else begin
                nxt.state = S_IDLE;
              end
            end
            PH_PTR: begin
              nxt.ptr = state_r.shift; // R15
              nxt.state = S_ACK;
              nxt.sda_oe = 1'b1;
              nxt.phase = PH_DATA;
            end
            default: begin
              wr_en = 1'b1;
              nxt.ptr = state_r.ptr + 8'h01; // R15
              nxt.state = S_ACK;
              nxt.sda_oe = 1'b1;
            end
          endcase
        end
      end
      S_ACK: begin
        if (scl_fall) begin
          if (state_r.rw) begin
            nxt.state = S_TX;
            nxt.shift = rd_byte; // R16
            nxt.ptr = state_r.ptr + 8'h01;
            nxt.sda_oe = ~rd_byte[7];
          end else begin
            nxt.state = S_RX;
            nxt.sda_oe = 1'b0;
          end
        end
      end
      S_TX: begin
        if (scl_fall) begin
          if (state_r.cnt == 4'h7) begin
            nxt.state = S_RACK;
            nxt.sda_oe = 1'b0;
            nxt.cnt = 4'h0;
          end else begin
            nxt.shift = {state_r.shift[6:0], 1'b0};
            nxt.cnt = state_r.cnt + 4'h1;
            nxt.sda_oe = ~state_r.shift[6];
          end
        end
      end
      S_RACK: begin
        if (scl_rise) begin
          nxt.acked = ~sda_i;
        end else if (scl_fall) begin
          if (state_r.acked) begin // R16
            nxt.state = S_TX;
            nxt.shift = rd_byte;
            nxt.ptr = state_r.ptr + 8'h01;
            nxt.sda_oe = ~rd_byte[7];
          end else begin
            nxt.state = S_IDLE;
          end
        end
      end
      default: begin
        nxt.state = S_IDLE;
        nxt.sda_oe = 1'b0;
      end
    endcase
    // Start or stop ends any transfer; a repeated start ends a sequential write
    if (start_cond) begin
      nxt.state = S_RX;
      nxt.phase = PH_ADDR;
      nxt.cnt = 4'h0;
      nxt.sda_oe = 1'b0;
    end else if (stop_cond) begin
      nxt.state = S_IDLE;
      nxt.sda_oe = 1'b0;
    end
    if (wr_en) begin
      nxt.regs = write_reg(state_r.regs, state_r.ptr, wr_data);
    end
    // Hardware set wins over a clear in the same cycle
    nxt.regs[1][FC_FLT_R] = nxt.regs[1][FC_FLT_R] | fault_right_i; // R08
    nxt.regs[1][FC_FLT_L] = nxt.regs[1][FC_FLT_L] | fault_left_i; // R10
    nxt.regs[1][FC_THERM] = nxt.regs[1][FC_THERM] | therm_hot; // R11 R12
    nxt.amp.right_amp_on = fc[FC_EN_R] & ~fc[FC_SWS] & ~therm_hot; // R05 R06
    nxt.amp.left_amp_on = fc[FC_EN_L] & ~fc[FC_SWS] & ~therm_hot; // R05 R06
    nxt.amp.bias_enable = ~fc[FC_SWS]; // R07
    nxt.amp.noise_gate_active = fc[FC_NG] & ~fc[FC_SWS] & (state_r.regs[7][1:0] != RATIO_1TO1); // R13 R14
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= CORE_RESET; // R01
    end else begin
      state_r <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_o = 1'b0;
  assign sda_oe_o = state_r.sda_oe;
  assign amp_o = state_r.amp;
  assign cfg_o = {state_r.regs[2], state_r.regs[3], state_r.regs[4], state_r.regs[5], state_r.regs[6],
                  state_r.regs[7]};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_reset_defaults;
    @(posedge clk) disable iff (1'b0) rst |=> (state_r.regs == REG_RESET);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("register defaults wrong after reset"); // R01

  property p_addr_match;
    (state_r.state == S_RX && state_r.phase == PH_ADDR && state_r.cnt == 4'h8 && scl_fall &&
     state_r.shift[7:1] == SLAVE_ADDR) |=> (state_r.state == S_ACK && sda_oe_o);
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("own address not acknowledged"); // R04

  property p_addr_miss;
    (state_r.state == S_RX && state_r.phase == PH_ADDR && state_r.cnt == 4'h8 && scl_fall &&
     state_r.shift[7:1] != SLAVE_ADDR) |=> (state_r.state == S_IDLE && !sda_oe_o);
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged"); // R04

  property p_hot_off;
    therm_hot |=> (!amp_o.right_amp_on && !amp_o.left_amp_on);
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("amplifier on while over temperature"); // R06

  property p_enable_on;
    (fc[FC_EN_R] && !fc[FC_SWS] && !therm_hot) |=> amp_o.right_amp_on;
  endproperty
  a_enable_on: assert property (p_enable_on) else $error("right amplifier not enabled"); // R05

  property p_shutdown;
    fc[FC_SWS] |=> (!amp_o.bias_enable && !amp_o.right_amp_on && !amp_o.noise_gate_active);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("software shutdown not applied"); // R07

  property p_fault_set;
    (fault_right_i || fault_left_i) |=>
      ((fc[FC_FLT_R] || !$past(fault_right_i)) && (fc[FC_FLT_L] || !$past(fault_left_i)));
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault flag not set"); // R08 R10

  property p_fault_hold;
    (fc[FC_FLT_R] && !(wr_en && state_r.ptr == REG_FUNC && !wr_data[FC_FLT_R])) |=> fc[FC_FLT_R];
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("right fault flag lost"); // R09

  property p_write_one;
    (wr_en && state_r.ptr == REG_FUNC && wr_data[FC_FLT_R] && !fc[FC_FLT_R] && !fault_right_i) |=>
      !fc[FC_FLT_R];
  endproperty
  a_write_one: assert property (p_write_one) else $error("flag set by host write"); // R17

  property p_therm_glitch;
    (!fc[FC_THERM] && !therm_hot) |=> !fc[FC_THERM];
  endproperty
  a_therm_glitch: assert property (p_therm_glitch) else $error("thermal flag set without qualification"); // R12

  property p_ng_ratio;
    (state_r.regs[7][1:0] == RATIO_1TO1) |=> !amp_o.noise_gate_active;
  endproperty
  a_ng_ratio: assert property (p_ng_ratio) else $error("noise gate active at 1:1 ratio"); // R13

  property p_seq_write;
    (wr_en && state_r.ptr == REG_ATTACK) |=>
      (state_r.regs[2] == ($past(wr_data) & REG_WMASK[2]) && state_r.ptr == 8'h03);
  endproperty
  a_seq_write: assert property (p_seq_write) else $error("sequential write wrong"); // R15

  property p_seq_read;
    (state_r.state == S_RACK && scl_fall && state_r.acked && !start_cond && !stop_cond) |=>
      (state_r.state == S_TX && state_r.shift == $past(rd_byte));
  endproperty
  a_seq_read: assert property (p_seq_read) else $error("next read byte not loaded"); // R16

  property p_bit_one;
    fc[1];
  endproperty
  a_bit_one: assert property (p_bit_one) else $error("unused bit not one"); // R18

  c_addr_ack: cover property (state_r.state == S_RX ##1 state_r.state == S_ACK);
  c_write: cover property (wr_en && state_r.ptr == REG_MAXGAIN);
  c_read_more: cover property (state_r.state == S_RACK ##1 state_r.state == S_TX);
  c_therm: cover property (!fc[FC_THERM] ##1 fc[FC_THERM]);

endmodule : acr_bank

//--- acr_bank_tb_top.sv
// Purpose: Self-checking bench of the amplifier control register bank
// Assumes: Short thermal qualification count in simulation
// Notes:   Register model kept in integers and compared after every transfer except the unacknowledged write
`timescale 1ns/1ps
module acr_bank_tb_top
  import acr_pkg::*;
;
  localparam int DG = 4;
  logic clk, rst, fr, fl, ot, scl, h_oe, sda_o, d_oe, sda, hot;
  acr_amp_type amp;
  acr_cfg_type cfg;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int m [1:7];

  // Wired data line with pull-up
  assign sda = ~h_oe & (d_oe ? sda_o : 1'b1);

  acr_bank #(.DEGLITCH(DG)) u_dut (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(d_oe), .fault_right_i(fr), .fault_left_i(fl), .over_temp_i(ot), .amp_o(amp), .cfg_o(cfg));
  acr_host_model u_host (.clk(clk), .sda_in(sda), .scl(scl), .sda_oe(h_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // Model and checks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic void mwr(input int a, input int d);
    if (a == 1) m[1] = (d & 8'he1) | 8'h02 | (m[1] & d & 8'h1c);
    else if (a == 6) m[6] = d;
    else if (a == 7) m[7] = d & 8'hf3;
    else if (a >= 2 && a <= 5) m[a] = d & 8'h3f;
  endfunction : mwr

  task automatic outs;
    logic s;
    logic [3:0] e;
    s = m[1][5];
    e = {m[1][7] & ~s & ~hot, m[1][6] & ~s & ~hot, ~s, m[1][0] & ~s & (m[7][1:0] != 2'h0)};
    chk("amp", {4'h0, e}, {4'h0, amp});
    for (int i = 0; i < 6; i++) chk("cfg", m[2 + i], cfg[47 - 8 * i -: 8]);
  endtask : outs

  task automatic rdall;
    u_host.rd_xfer(8'h01, 7);
    chk("ack", 8'h01, {7'h0, u_host.ok});
    for (int i = 0; i < 7; i++) chk("reg", m[i + 1], u_host.rd[i]);
  endtask : rdall

  task automatic wr(input logic [7:0] p, input int n);
    u_host.wr_xfer(8'hb0, p, n);
    for (int i = 0; i < n; i++) mwr(p + i, u_host.wd[i]);
    repeat (3) @(posedge clk);
    outs();
  endtask : wr

  task automatic w1(input logic [7:0] p, input logic [7:0] d);
    u_host.wd[0] = d;
    wr(p, 1);
  endtask : w1

  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    automatic logic [7:0] fv [6] = '{8'h20, 8'h41, 8'h81, 8'h00, 8'hff, 8'hc3};
    rst = 1'b1;
    fr = 1'b0;
    fl = 1'b0;
    ot = 1'b0;
    hot = 1'b0;
    m = '{8'hc3, 8'h05, 8'h0b, 8'h00, 8'h06, 8'h3a, 8'hc2};
    void'($urandom(40764));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    outs();
    rdall();
    u_host.wd[0] = 8'h55;
    u_host.wr_xfer(8'ha0, 8'h02, 1);
    chk("nack", 8'h00, {7'h0, u_host.ok});
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 6; i++) u_host.wd[i] = 8'($urandom);
      wr(8'h02, 6);
      rdall();
    end
    w1(8'h08, 8'hff);
    w1(8'h07, 8'h01);
    for (int i = 0; i < 6; i++) begin
      w1(8'h01, fv[i]);
      rdall();
    end
    w1(8'h07, 8'hf0);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) fr <= 1'b1;
      else fl <= 1'b1;
      @(posedge clk);
      fr <= 1'b0;
      fl <= 1'b0;
      m[1] |= (k == 0) ? 8'h10 : 8'h08;
      w1(8'h01, 8'hdd);
      rdall();
      w1(8'h01, 8'hc1);
      rdall();
    end
    ot <= 1'b1;
    repeat (DG - 1) @(posedge clk);
    ot <= 1'b0;
    repeat (3) @(posedge clk);
    outs();
    rdall();
    ot <= 1'b1;
    repeat (DG + 4) @(posedge clk);
    hot = 1'b1;
    m[1] |= 8'h04;
    outs();
    ot <= 1'b0;
    repeat (3) @(posedge clk);
    hot = 1'b0;
    outs();
    rdall();
    w1(8'h01, 8'hc1);
    rdall();
    summarize();
  end
endmodule : acr_bank_tb_top

//--- acr_deglitch.sv
// Purpose: Qualifies a level that must stay high for a number of cycles
// Assumes: Input synchronous to clk
// Notes:   Output drops in the cycle after the input drops
`timescale 1ns/1ps
module acr_deglitch
  import acr_pkg::*;
#(
  parameter int CYCLES = DEGLITCH_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and qualified level out
  input wire logic level_i,
  output logic stable_o
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic stable;
  } acr_dg_type;

  acr_dg_type dg_r;
  acr_dg_type dg_nxt;

  always_comb begin
    dg_nxt = dg_r;
    if (!level_i) begin
      dg_nxt.cnt = '0;
      dg_nxt.stable = 1'b0;
    end else if (dg_r.cnt == CW'(CYCLES - 1)) begin
      dg_nxt.stable = 1'b1;
    end else begin
      dg_nxt.cnt = dg_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dg_r <= '0;
    end else begin
      dg_r <= dg_nxt;
    end
  end

  assign stable_o = dg_r.stable;

endmodule : acr_deglitch

//--- acr_host_model.sv
// Purpose: Two-wire serial bus master that drives the amplifier register bank
// Assumes: Open-drain data line with pull-up; the bench resolves the wired level
// Notes:   Clock line high and low phases are four system clocks each
`timescale 1ns/1ps
module acr_host_model (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sda_in,
  output logic scl,
  output logic sda_oe
);
  logic [7:0] wd [0:7];
  logic [7:0] rd [0:7];
  logic ok;
  logic r;

  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // ------------------------------------------------------------
  // Bit level
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic start_c;
    sda_oe <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_oe <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask : start_c

  task automatic stop_c;
    sda_oe <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_oe <= 1'b0;
    tick(4);
  endtask : stop_c

  // Data changes only while the clock line is low
  task automatic bit_io(input logic b);
    sda_oe <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sda_in;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask : bit_io

  task automatic tx_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(d[i]);
    bit_io(1'b1);
    ok &= ~r;
  endtask : tx_byte

  task automatic rx_byte(input int k, input logic last);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1);
      rd[k][i] = r;
    end
    bit_io(last);
  endtask : rx_byte

  // ------------------------------------------------------------
  // Transfers
  // ------------------------------------------------------------
  task automatic wr_xfer(input logic [7:0] a, input logic [7:0] p, input int n);
    if (p + n > 9) return;
    ok = 1'b1;
    start_c();
    tx_byte(a);
    tx_byte(p);
    for (int i = 0; i < n; i++) tx_byte(wd[i]);
    stop_c();
  endtask : wr_xfer

  task automatic rd_xfer(input logic [7:0] p, input int n);
    if (p + n > 8) return;
    ok = 1'b1;
    start_c();
    tx_byte(8'hb0);
    tx_byte(p);
    start_c();
    tx_byte(8'hb1);
    for (int i = 0; i < n; i++) rx_byte(i, i == n - 1);
    stop_c();
  endtask : rd_xfer
endmodule : acr_host_model

//--- acr_pkg.sv
// Purpose: Shared constants and types of the amplifier control register bank
// Assumes: 50 MHz system clock, two-wire serial bus sampled on that clock
// Notes:   Register index equals the register byte sent by the bus master
package acr_pkg;

  // ----------------------------------------------------------------
  // Bus address and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h58;
  localparam logic [7:0] REG_FUNC = 8'h01;
  localparam logic [7:0] REG_ATTACK = 8'h02;
  localparam logic [7:0] REG_MAXGAIN = 8'h07;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Reset values, index 0 unused
  localparam logic [7:0][7:0] REG_RESET = {8'hc2, 8'h3a, 8'h06, 8'h00, 8'h0b, 8'h05, 8'hc3, 8'h00};
  // Writable bits of registers two to seven
  localparam logic [7:0][7:0] REG_WMASK = {8'hf3, 8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h00, 8'h00};

  // ----------------------------------------------------------------
  // Function control fields
  // ----------------------------------------------------------------
  localparam int FC_EN_R = 7;
  localparam int FC_EN_L = 6;
  localparam int FC_SWS = 5;
  localparam int FC_FLT_R = 4;
  localparam int FC_FLT_L = 3;
  localparam int FC_THERM = 2;
  localparam int FC_NG = 0;
  localparam logic [7:0] FC_WMASK = 8'he1;
  localparam logic [7:0] FC_FLAGS = 8'h1c;
  localparam logic [7:0] FC_ONE = 8'h02;
  localparam logic [1:0] RATIO_1TO1 = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int DEGLITCH_US = 10;
  localparam int DEGLITCH_CYCLES = (CLK_FREQ_HZ / 1_000_000) * DEGLITCH_US;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RX   = 5'h02,
    S_ACK  = 5'h04,
    S_TX   = 5'h08,
    S_RACK = 5'h10
  } acr_state_type;

  typedef enum logic [2:0] {
    PH_ADDR = 3'h1,
    PH_PTR  = 3'h2,
    PH_DATA = 3'h4
  } acr_phase_type;

  typedef struct packed {
    logic [7:0] attack_time;
    logic [7:0] release_time;
    logic [7:0] hold_time;
    logic [7:0] fixed_gain;
    logic [7:0] limiter_noise_gate;
    logic [7:0] max_gain_compression;
  } acr_cfg_type;

  typedef struct packed {
    logic right_amp_on;
    logic left_amp_on;
    logic bias_enable;
    logic noise_gate_active;
  } acr_amp_type;

  typedef struct packed {
    acr_state_type state;
    acr_phase_type phase;
    logic rw;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [7:0][7:0] regs;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic acked;
    acr_amp_type amp;
  } acr_core_type;

  localparam acr_core_type CORE_RESET = '{
    state: S_IDLE, phase: PH_ADDR, rw: 1'b0, cnt: 4'h0, shift: 8'h00, ptr: 8'h00,
    regs: REG_RESET, scl_q: 1'b1, sda_q: 1'b1, sda_oe: 1'b0, acked: 1'b0, amp: 4'h0};

endpackage : acr_pkg
